// ==== src/acc_pkg.sv ====
/*
  Package for the converter conversion control block: register map, field
  positions, reset values, timing counts and carrier types.
  Assumes a plain register port with 8-bit data and one-cycle read latency.
*/
package acc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [2:0] ACC_OFS_CTRL_STATUS = 3'h0;
  localparam logic [2:0] ACC_OFS_RESULT_LOW = 3'h1;
  localparam logic [2:0] ACC_OFS_RESULT_HIGH = 3'h2;
  localparam logic [2:0] ACC_OFS_CHANNEL = 3'h3;
  localparam logic [2:0] ACC_OFS_IRQ_STATUS = 3'h4;
  localparam logic [2:0] ACC_OFS_IRQ_MASK = 3'h5;

  // ----------------------------------------------------------------------
  // Control and status fields
  // ----------------------------------------------------------------------
  localparam int ACC_BIT_ENABLE = 7;
  localparam int ACC_BIT_START = 6;
  localparam int ACC_BIT_DONE = 4;
  localparam int ACC_DIV_LSB = 0;
  localparam int ACC_DIV_W = 3;
  localparam int ACC_IRQ_DONE = 0;
  localparam int ACC_IRQ_LOST = 1;

  // ----------------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [7:0] ACC_RST_BYTE = 8'h00;
  localparam logic [9:0] ACC_RST_RESULT = 10'h000;
  localparam int ACC_CONV_CYCLES = 13;
  localparam int ACC_INIT_EXTRA_CYCLES = 13;
  localparam int ACC_RESULT_W = 10;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } acc_bus_s;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_INIT = 2'b01,
    ACC_CONV = 2'b11
  } acc_state_e;

endpackage

// ==== src/acc_conv_ctrl.sv ====
/*
  Conversion control for a 10-bit converter: enable, start, prescaler,
  dummy first conversion, deferred channel change, result lock, interrupt.
  Assumes the analog core supplies a sample on sample_i when sample_take_o.
*/
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module acc_conv_ctrl #(
  parameter int CONV_CYCLES = acc_pkg::ACC_CONV_CYCLES,
  parameter int INIT_EXTRA = acc_pkg::ACC_INIT_EXTRA_CYCLES,
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Analog core
  input wire logic [9:0] sample_i,
  output logic sample_take_o,
  output logic [2:0] channel_o,
  output logic conv_clk_o,
  // Interrupt
  output logic irq_o
);

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  acc_pkg::acc_bus_s bus;
  assign bus = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

  logic wr_ctrl;
  logic wr_chan;
  logic wr_mask;
  logic rd_low;
  logic rd_high;
  logic rd_irq;
  assign wr_ctrl = bus.wr && (bus.addr == acc_pkg::ACC_OFS_CTRL_STATUS);
  assign wr_chan = bus.wr && (bus.addr == acc_pkg::ACC_OFS_CHANNEL);
  assign wr_mask = bus.wr && (bus.addr == acc_pkg::ACC_OFS_IRQ_MASK);
  assign rd_low = bus.rd && (bus.addr == acc_pkg::ACC_OFS_RESULT_LOW);
  assign rd_high = bus.rd && (bus.addr == acc_pkg::ACC_OFS_RESULT_HIGH);
  assign rd_irq = bus.rd && (bus.addr == acc_pkg::ACC_OFS_IRQ_STATUS);

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  logic conv_enable;
  logic [acc_pkg::ACC_DIV_W-1:0] conv_clk_div_sel;
  logic need_init;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      conv_enable <= 1'b0;
      conv_clk_div_sel <= 3'h0;
    end else if (wr_ctrl) begin
      conv_enable <= bus.wdata[acc_pkg::ACC_BIT_ENABLE];
      conv_clk_div_sel <= bus.wdata[acc_pkg::ACC_DIV_LSB +: acc_pkg::ACC_DIV_W];
    end
  end

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  // Ratio is 2 to the power (select + 1), so select 7 divides by 256.
  logic [DIV_W-1:0] pre_cnt;
  logic [DIV_W-1:0] pre_mask;
  logic conv_tick;
  assign pre_mask = DIV_W'((9'h001 << ({6'h00, conv_clk_div_sel} + 9'h001)) - 9'h001);
  assign conv_tick = conv_enable && ((pre_cnt & pre_mask) == pre_mask);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_cnt <= '0;
    end else if (!conv_enable) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= pre_cnt + DIV_W'(1);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      conv_clk_o <= 1'b0;
    end else begin
      conv_clk_o <= conv_enable && ((pre_cnt & pre_mask) > (pre_mask >> 1));
    end
  end

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  acc_pkg::acc_state_e state;
  logic [5:0] tick_cnt;
  logic conv_start;
  logic conv_end;
  logic start_req;
  assign start_req = wr_ctrl && bus.wdata[acc_pkg::ACC_BIT_START] && conv_enable
                     && bus.wdata[acc_pkg::ACC_BIT_ENABLE];
  assign conv_end = (state == acc_pkg::ACC_CONV) && conv_tick
                    && (tick_cnt == 6'(CONV_CYCLES - 1));

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= acc_pkg::ACC_IDLE;
      tick_cnt <= 6'h00;
    end else if (!conv_enable) begin
      state <= acc_pkg::ACC_IDLE;
      tick_cnt <= 6'h00;
    end else begin
      case (state)
        acc_pkg::ACC_IDLE: begin
          tick_cnt <= 6'h00;
          if (start_req && !conv_start) begin
            state <= need_init ? acc_pkg::ACC_INIT : acc_pkg::ACC_CONV;
          end
        end
        acc_pkg::ACC_INIT: begin
          if (conv_tick) begin
            if (tick_cnt == 6'(INIT_EXTRA - 1)) begin
              tick_cnt <= 6'h00;
              state <= acc_pkg::ACC_CONV;
            end else begin
              tick_cnt <= tick_cnt + 6'h01;
            end
          end
        end
        acc_pkg::ACC_CONV: begin
          if (conv_tick) begin
            if (conv_end) begin
              tick_cnt <= 6'h00;
              state <= acc_pkg::ACC_IDLE;
            end else begin
              tick_cnt <= tick_cnt + 6'h01;
            end
          end
        end
        default: begin
          state <= acc_pkg::ACC_IDLE;
          tick_cnt <= 6'h00;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      conv_start <= 1'b0;
    end else if (!conv_enable) begin
      conv_start <= 1'b0;
    end else if (conv_end) begin
      conv_start <= 1'b0;
    end else if (start_req && state == acc_pkg::ACC_IDLE) begin
      // A start landing on the final tick is ignored, so busy cannot stick high.
      conv_start <= 1'b1;
    end
  end

  // Dummy conversion is owed again each time the converter is re-enabled.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      need_init <= 1'b1;
    end else if (!conv_enable) begin
      need_init <= 1'b1;
    end else if (state == acc_pkg::ACC_INIT) begin
      need_init <= 1'b0;
    end
  end

  assign sample_take_o = conv_end;

  // ----------------------------------------------------------------------
  // Channel select
  // ----------------------------------------------------------------------
  logic [2:0] chan_pending;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chan_pending <= 3'h0;
    end else if (wr_chan) begin
      chan_pending <= bus.wdata[2:0];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      channel_o <= 3'h0;
    end else if (state == acc_pkg::ACC_IDLE && !start_req) begin
      channel_o <= chan_pending;
    end else if (state == acc_pkg::ACC_IDLE) begin
      channel_o <= wr_chan ? bus.wdata[2:0] : chan_pending;
    end
  end

  // ----------------------------------------------------------------------
  // Result registers with read lock
  // ----------------------------------------------------------------------
  logic [acc_pkg::ACC_RESULT_W-1:0] result;
  logic locked;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      locked <= 1'b0;
    end else if (rd_low) begin
      locked <= 1'b1;
    end else if (rd_high) begin
      locked <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      result <= acc_pkg::ACC_RST_RESULT;
    end else if (conv_end && !locked) begin
      result <= sample_i;
    end
  end

  // ----------------------------------------------------------------------
  // Completion flag and interrupt
  // ----------------------------------------------------------------------
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic conv_done_flag;
  logic lost_ev;
  assign lost_ev = conv_end && locked;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_status <= 2'b00;
    end else begin
      irq_status[acc_pkg::ACC_IRQ_DONE] <= conv_end
        || (irq_status[acc_pkg::ACC_IRQ_DONE] && !rd_irq);
      irq_status[acc_pkg::ACC_IRQ_LOST] <= lost_ev
        || (irq_status[acc_pkg::ACC_IRQ_LOST] && !rd_irq);
    end
  end

  assign conv_done_flag = irq_status[acc_pkg::ACC_IRQ_DONE];

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_mask <= 2'b00;
    end else if (wr_mask) begin
      irq_mask <= bus.wdata[1:0];
    end
  end

  assign irq_o = |(irq_status & irq_mask);

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = acc_pkg::ACC_RST_BYTE;
    case (bus.addr)
      acc_pkg::ACC_OFS_CTRL_STATUS: begin
        next_rdata[acc_pkg::ACC_BIT_ENABLE] = conv_enable;
        next_rdata[acc_pkg::ACC_BIT_START] = conv_start;
        next_rdata[acc_pkg::ACC_BIT_DONE] = conv_done_flag;
        next_rdata[acc_pkg::ACC_DIV_LSB +: acc_pkg::ACC_DIV_W] = conv_clk_div_sel;
      end
      acc_pkg::ACC_OFS_RESULT_LOW: next_rdata = result[7:0];
      acc_pkg::ACC_OFS_RESULT_HIGH: next_rdata = {6'h00, result[9:8]};
      acc_pkg::ACC_OFS_CHANNEL: next_rdata = {5'h00, chan_pending};
      acc_pkg::ACC_OFS_IRQ_STATUS: next_rdata = {6'h00, irq_status};
      acc_pkg::ACC_OFS_IRQ_MASK: next_rdata = {6'h00, irq_mask};
      default: next_rdata = acc_pkg::ACC_RST_BYTE;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= acc_pkg::ACC_RST_BYTE;
    end else if (bus.rd) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= acc_pkg::ACC_RST_BYTE;
    end
  end

endmodule

`default_nettype wire

// ==== sim/acc_conv_ctrl_monitor.sv ====
/*
  Port checker for acc_conv_ctrl, bound to the design top module.
  Assumes the single core clock and the active high asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module acc_conv_ctrl_monitor (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Core side
  input wire logic sample_take_o,
  input wire logic [2:0] channel_o,
  input wire logic conv_clk_o,
  input wire logic irq_o
);
  // ------------------------------------------------------------
  // Shadow of enable, busy and mask
  // ------------------------------------------------------------
  logic en;
  logic pend;
  logic [1:0] msk;
  logic wc;
  assign wc = wr_i && addr_i == acc_pkg::ACC_OFS_CTRL_STATUS;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      en <= 1'b0;
      pend <= 1'b0;
      msk <= 2'b00;
    end else begin
      if (wc) en <= wdata_i[7];
      if (wc && !wdata_i[7]) pend <= 1'b0;
      else if (sample_take_o) pend <= 1'b0;
      else if (wc && wdata_i[6] && en) pend <= 1'b1;
      if (wr_i && addr_i == acc_pkg::ACC_OFS_IRQ_MASK) msk <= wdata_i[1:0];
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero");
  a_take_pulse: assert property (sample_take_o |=> !sample_take_o)
    else $error("end pulse too long");
  a_take_started: assert property (sample_take_o |-> pend)
    else $error("conversion without start");
  a_take_enabled: assert property (sample_take_o |-> en)
    else $error("conversion while disabled");
  a_chan_held: assert property (pend && $past(pend) |-> $stable(channel_o))
    else $error("channel changed mid conversion");
  a_busy_bit: assert property (rd_i && addr_i == acc_pkg::ACC_OFS_CTRL_STATUS &&
    !sample_take_o |=> rdata_o[6] == $past(pend)) else $error("start bit wrong");
  a_irq_done: assert property (sample_take_o && msk[0] &&
    !(wr_i && addr_i == acc_pkg::ACC_OFS_IRQ_MASK) |=> irq_o) else $error("no irq");
  a_irq_masked: assert property (msk == 2'b00 |-> !irq_o)
    else $error("irq while masked");
  a_clk_still: assert property (!en && !$past(en) |-> !conv_clk_o)
    else $error("converter clock while disabled");
  c_take: cover property (sample_take_o);
  c_clk: cover property ($rose(conv_clk_o));
  c_irq: cover property ($rose(irq_o));
  c_chan: cover property (pend && wr_i && addr_i == acc_pkg::ACC_OFS_CHANNEL);
endmodule
bind acc_conv_ctrl acc_conv_ctrl_monitor acc_conv_ctrl_monitor_i (.core_clk_i, .rst_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sample_take_o, .channel_o, .conv_clk_o, .irq_o);
`default_nettype wire

// ==== sim/acc_conv_ctrl_test.sv ====
/*
  Self-checking bench for acc_conv_ctrl.
  Assumes the bound monitor; the bench plays software and the analog core.
*/
`timescale 1ns/1ps
`default_nettype none
module acc_conv_ctrl_test;
  // ------------------------------------------------------------
  // Signals and register table
  // ------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [2:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } acc_row_s;
  localparam logic [2:0] CS = acc_pkg::ACC_OFS_CTRL_STATUS;
  localparam logic [2:0] IS = acc_pkg::ACC_OFS_IRQ_STATUS;
  localparam logic [2:0] IM = acc_pkg::ACC_OFS_IRQ_MASK;
  localparam logic [2:0] CH = acc_pkg::ACC_OFS_CHANNEL;
  localparam int TK = acc_pkg::ACC_CONV_CYCLES;
  localparam int IX = acc_pkg::ACC_INIT_EXTRA_CYCLES;
  logic core_clk_i, rst_i, wr_i, rd_i, sample_take_o, conv_clk_o, irq_o;
  logic [2:0] addr_i, channel_o, cur;
  logic [7:0] wdata_i, rdata_o, q;
  logic [9:0] sample_i;
  int miscompares, checks_done;
  acc_row_s rows [9] = '{'{1'b0, CS, 8'h00, 8'h00}, '{1'b0, IS, 8'h00, 8'h00},
    '{1'b1, IM, 8'h03, 8'h03}, '{1'b1, CS, 8'h42, 8'h02}, '{1'b1, CH, 8'h05, 8'h05},
    '{1'b1, 3'h7, 8'hFF, 8'h00}, '{1'b0, acc_pkg::ACC_OFS_RESULT_LOW, 8'h00, 8'h00},
    '{1'b0, acc_pkg::ACC_OFS_RESULT_HIGH, 8'h00, 8'h00}, '{1'b1, IM, 8'h01, 8'h01}};
  acc_conv_ctrl acc_conv_ctrl_i (.core_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .sample_i, .sample_take_o, .channel_o, .conv_clk_o, .irq_o);
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [2:0] a);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 q = rdata_o;
    @(posedge core_clk_i);
  endtask
  task automatic res(input logic [9:0] v);
    rd(acc_pkg::ACC_OFS_RESULT_LOW);
    chk("result low", v[7:0], q);
    rd(acc_pkg::ACC_OFS_RESULT_HIGH);
    chk("result high", {6'h00, v[9:8]}, q);
  endtask
  // The prescaler phase at start is not visible, so one period of slack.
  task automatic conv(input logic [2:0] s, input int tk, input logic [2:0] ch);
    int n;
    int p;
    p = 2 << s;
    wr(CS, {5'b11000, s});
    rd(CS);
    chk("busy", 8'h40, q & 8'h40);
    wr(CS, {5'b10000, s});
    wr(CH, {5'b00000, ch});
    chk("chan held", {5'h00, cur}, {5'h00, channel_o});
    n = 7;
    #1;
    while (sample_take_o !== 1'b1 && n < tk * p + 2 * p + 20) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    chk("length", 8'h01, {7'h00, n >= tk * p - p - 1 && n <= tk * p + p + 1});
    // The first edge lets the flag and irq settle; the second is margin before anyone looks.
    @(posedge core_clk_i);
    @(posedge core_clk_i);
    cur = ch;
  endtask
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    summarize;
  end
  initial begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    sample_i = 10'h2A5;
    miscompares = 0;
    checks_done = 0;
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    chk("reset outs", 8'h00, {2'b00, irq_o, sample_take_o, conv_clk_o, channel_o});
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk("row", rows[i].e, q);
    end
    chk("chan idle", 8'h05, {5'h00, channel_o});
    cur = 3'h5;
    wr(CS, 8'h80);
    conv(3'h0, TK + IX, 3'h6);
    chk("irq", 8'h01, {7'h00, irq_o});
    res(10'h2A5);
    chk("chan applied", 8'h06, {5'h00, channel_o});
    rd(IS);
    chk("irq status", 8'h01, q);
    rd(IS);
    chk("irq cleared", 8'h00, q);
    sample_i <= 10'h15A;
    conv(3'h0, TK, 3'h1);
    res(10'h15A);
    rd(IS);
    rd(acc_pkg::ACC_OFS_RESULT_LOW);
    sample_i <= 10'h3FF;
    conv(3'h0, TK, 3'h2);
    res(10'h15A);
    rd(IS);
    chk("lost irq", 8'h03, q);
    wr(CS, 8'h81);
    conv(3'h1, TK, 3'h3);
    res(10'h3FF);
    sample_i <= 10'h0C3;
    wr(CS, 8'h87);
    conv(3'h7, TK, 3'h4);
    res(10'h0C3);
    rd(IS);
    chk("done only", 8'h01, q);
    wr(CS, 8'hC0);
    wr(CS, 8'h00);
    rd(CS);
    chk("abort", 8'h00, q);
    wr(CS, 8'h80);
    wr(CS, 8'hC0);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    rd(CS);
    chk("reset busy", 8'h00, q);
    rd(IM);
    chk("reset mask", 8'h00, q);
    wr(CS, 8'h00);
    repeat (4) @(posedge core_clk_i);
    chk("clk idle", 8'h00, {7'h00, conv_clk_o});
    summarize;
  end
endmodule
`default_nettype wire
